// ---- hdl/flash_bus_cycle.sv ----
`timescale 1ns/1ps
// one strobed bus cycle: chip select and write or output enable
module flash_bus_cycle
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [18:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] dq_in,
  output logic busy,
  output logic done,
  output logic [15:0] rdata,
  output logic [18:0] a_out,
  output logic [15:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  typedef enum logic [3:0]
  {
    ph_idle = 4'b0001,
    ph_setup = 4'b0010,
    ph_pulse = 4'b0100,
    ph_hold = 4'b1000
  } phase_t;
  phase_t phase;
  logic [3:0] cnt;
  logic wr;
  logic [15:0] dq_s1;
  logic [15:0] dq_s2;
  wire last = cnt == 4'h0;
  // address and data are set during setup; strobes open later and close
  // first, so the device latches address on its falling edge and data on
  // its rising edge
  always_ff @(posedge clk)
  begin
    dq_s1 <= dq_in;
    dq_s2 <= dq_s1;
    done <= 1'b0;
    if (rst)
    begin
      phase <= ph_idle;
      cnt <= 4'h0;
      wr <= 1'b0;
      a_out <= 19'h00000;
      dq_out <= 16'h0000;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      rdata <= 16'h0000;
    end
    else
    begin
      case (phase)
        ph_idle:
        begin
          if (start)
          begin
            wr <= is_write;
            a_out <= addr;
            dq_out <= wdata;
            dq_oe <= is_write;
            ce_n <= 1'b0;
            cnt <= 4'(flash_cmd_pkg::n_setup - 1);
            phase <= ph_setup;
          end
        end
        ph_setup:
        begin
          cnt <= cnt - 4'h1;
          if (last)
          begin
            we_n <= ~wr;
            oe_n <= wr;
            cnt <= wr ? 4'(flash_cmd_pkg::n_pulse - 1)
                      : 4'(flash_cmd_pkg::n_access + 1);
            phase <= ph_pulse;
          end
        end
        ph_pulse:
        begin
          cnt <= cnt - 4'h1;
          if (last)
          begin
            // read data has passed the two-stage synchroniser by now
            if (!wr)
              rdata <= dq_s2;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            cnt <= 4'(flash_cmd_pkg::n_hold - 1);
            phase <= ph_hold;
          end
        end
        ph_hold:
        begin
          cnt <= cnt - 4'h1;
          if (last)
          begin
            ce_n <= 1'b1;
            dq_oe <= 1'b0;
            done <= 1'b1;
            phase <= ph_idle;
          end
        end
        default: phase <= ph_idle;
      endcase
    end
  end
  assign busy = phase != ph_idle;
endmodule : flash_bus_cycle

// ---- hdl/flash_cmd_host.sv ----
`timescale 1ns/1ps
// host side command sequencer: turns one operation request into the
// string of bus writes and reads that the flash expects
module flash_cmd_host
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [18:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic byte_mode,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic [18:0] a_out,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in,
  output logic ce_n,
  output logic we_n,
  output logic oe_n
);
  typedef enum logic [2:0]
  {
    st_idle = 3'b001,
    st_issue = 3'b010,
    st_wait = 3'b100
  } state_t;
  state_t state;
  logic [3:0] op;
  logic [18:0] taddr;
  logic [15:0] tdata;
  logic bmode;
  logic [2:0] step;
  logic cyc_start;
  logic cyc_busy;
  logic cyc_done;
  logic [15:0] cyc_rdata;

  // one entry of a sequence: last flag, write flag, address and data
  typedef struct packed
  {
    logic last;
    logic wr;
    logic [18:0] a;
    logic [15:0] d;
  } step_t;

  function automatic logic [15:0] cmd(input logic [7:0] c);
    cmd = {8'h00, c}; // upper byte is ignored by the device
  endfunction : cmd

  function automatic step_t mk(input logic l, input logic w,
    input logic [18:0] a, input logic [15:0] d);
    mk = '{last: l, wr: w, a: a, d: d};
  endfunction : mk

  // unlock pair plus one command word at the first unlock address
  function automatic step_t unlock(input logic [2:0] s, input logic bm,
    input logic [7:0] c, input logic l);
    logic [18:0] u1;
    logic [18:0] u2;
    u1 = bm ? flash_cmd_pkg::unlock1_byte : flash_cmd_pkg::unlock1_word;
    u2 = bm ? flash_cmd_pkg::unlock2_byte : flash_cmd_pkg::unlock2_word;
    case (s)
      3'h0: unlock = mk(1'b0, 1'b1, u1, cmd(flash_cmd_pkg::d_unlock1));
      3'h1: unlock = mk(1'b0, 1'b1, u2, cmd(flash_cmd_pkg::d_unlock2));
      default: unlock = mk(l, 1'b1, u1, cmd(c)); // low bits only
    endcase
  endfunction : unlock

  wire [18:0] u1_addr = bmode ? flash_cmd_pkg::unlock1_byte
                              : flash_cmd_pkg::unlock1_word;
  wire [18:0] sect_addr = {taddr[18:flash_cmd_pkg::sector_lsb],
                           12'h000};
  wire [18:0] dev_addr = bmode ? flash_cmd_pkg::id_dev_byte
                               : flash_cmd_pkg::id_dev_word;
  wire [18:0] prot_addr = sect_addr | (bmode ? flash_cmd_pkg::id_prot_byte
                                             : flash_cmd_pkg::id_prot_word);
  wire [18:0] cfi_addr = bmode ? flash_cmd_pkg::cfi_byte
                               : flash_cmd_pkg::cfi_word;
  step_t cur;

  // step table per operation
  always_comb
  begin
    cur = mk(1'b1, 1'b0, taddr, 16'h0000);
    case (op)
      flash_cmd_pkg::op_read: cur = mk(1'b1, 1'b0, taddr, 16'h0000);
      flash_cmd_pkg::op_reset:
        cur = mk(1'b1, 1'b1, taddr, cmd(flash_cmd_pkg::d_reset));
      flash_cmd_pkg::op_id_maker, flash_cmd_pkg::op_id_device,
      flash_cmd_pkg::op_prot_verify:
      begin
        if (step < 3'h3)
          cur = unlock(step, bmode, flash_cmd_pkg::d_autosel, 1'b0);
        else if (op == flash_cmd_pkg::op_id_maker)
          cur = mk(1'b1, 1'b0, flash_cmd_pkg::id_maker, 16'h0000);
        else if (op == flash_cmd_pkg::op_id_device)
          cur = mk(1'b1, 1'b0, dev_addr, 16'h0000);
        else
          cur = mk(1'b1, 1'b0, prot_addr, 16'h0000);
      end
      flash_cmd_pkg::op_secure_enter:
        cur = unlock(step, bmode, flash_cmd_pkg::d_secure, 1'b1);
      flash_cmd_pkg::op_secure_exit:
      begin
        if (step < 3'h3)
          cur = unlock(step, bmode, flash_cmd_pkg::d_autosel, 1'b0);
        else
          cur = mk(1'b1, 1'b1, taddr, cmd(flash_cmd_pkg::d_zero));
      end
      flash_cmd_pkg::op_cfi:
        cur = mk(1'b1, 1'b1, cfi_addr, cmd(flash_cmd_pkg::d_cfi));
      flash_cmd_pkg::op_program:
      begin
        if (step < 3'h3)
          cur = unlock(step, bmode, flash_cmd_pkg::d_program, 1'b0);
        else
          cur = mk(1'b1, 1'b1, taddr, tdata);
      end
      flash_cmd_pkg::op_bypass_enter:
        cur = unlock(step, bmode, flash_cmd_pkg::d_bypass, 1'b1);
      flash_cmd_pkg::op_bypass_prog:
      begin
        if (step == 3'h0)
          cur = mk(1'b0, 1'b1, taddr, cmd(flash_cmd_pkg::d_program));
        else
          cur = mk(1'b1, 1'b1, taddr, tdata);
      end
      flash_cmd_pkg::op_bypass_exit:
      begin
        if (step == 3'h0)
          cur = mk(1'b0, 1'b1, taddr, cmd(flash_cmd_pkg::d_autosel));
        else
          cur = mk(1'b1, 1'b1, taddr, cmd(flash_cmd_pkg::d_zero));
      end
      flash_cmd_pkg::op_chip_erase, flash_cmd_pkg::op_sector_erase:
      begin
        if (step < 3'h3)
          cur = unlock(step, bmode, flash_cmd_pkg::d_erase_setup, 1'b0);
        else if (step < 3'h5)
          cur = unlock(step - 3'h3, bmode, 8'h00, 1'b0);
        else if (op == flash_cmd_pkg::op_chip_erase)
          cur = mk(1'b1, 1'b1, u1_addr,
                   cmd(flash_cmd_pkg::d_chip_erase));
        else
          cur = mk(1'b1, 1'b1, sect_addr,
                   cmd(flash_cmd_pkg::d_sector_erase));
      end
      flash_cmd_pkg::op_sector_add:
        cur = mk(1'b1, 1'b1, sect_addr,
                 cmd(flash_cmd_pkg::d_sector_erase));
      flash_cmd_pkg::op_suspend_resume:
        // data bit 0 picks resume, else suspend
        cur = mk(1'b1, 1'b1, taddr, cmd(tdata[0] ? flash_cmd_pkg::d_resume
                                                 : flash_cmd_pkg::d_suspend));
      default: cur = mk(1'b1, 1'b0, taddr, 16'h0000);
    endcase
  end

  // busy guard keeps a new request out while a strobe cycle still closes
  assign req_ready = state == st_idle && !cyc_busy;
  assign cyc_start = state == st_issue;

  // sequencer: one step per bus cycle, answer on the last
  always_ff @(posedge clk)
  begin
    rsp_valid <= 1'b0;
    if (rst)
    begin
      state <= st_idle;
      op <= flash_cmd_pkg::op_read;
      taddr <= 19'h00000;
      tdata <= 16'h0000;
      bmode <= 1'b0;
      step <= 3'h0;
      rsp_data <= 16'h0000;
    end
    else
    begin
      case (state)
        st_idle:
          if (req_valid)
          begin
            op <= req_op;
            taddr <= req_addr;
            tdata <= req_data;
            bmode <= byte_mode;
            step <= 3'h0;
            state <= st_issue;
          end
        st_issue: state <= st_wait;
        st_wait:
          if (cyc_done)
          begin
            if (cur.last)
            begin
              rsp_valid <= 1'b1;
              rsp_data <= cur.wr ? 16'h0000 : cyc_rdata;
              state <= st_idle;
            end
            else
            begin
              step <= step + 3'h1;
              state <= st_issue;
            end
          end
        default: state <= st_idle;
      endcase
    end
  end

  flash_bus_cycle u_cycle
  (
    .clk(clk),
    .rst(rst),
    .start(cyc_start),
    .is_write(cur.wr),
    .addr(cur.a),
    .wdata(cur.d),
    .dq_in(dq_in),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .a_out(a_out),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n)
  );
endmodule : flash_cmd_host

// ---- hdl/flash_cmd_pkg.sv ----
package flash_cmd_pkg;
  localparam int addr_w = 19;
  localparam int data_w = 16;
  // unlock, cfi, id and sector addresses, word and byte mode
  localparam logic [18:0] unlock1_word = 19'h00555;
  localparam logic [18:0] unlock2_word = 19'h002aa;
  localparam logic [18:0] unlock1_byte = 19'h00aaa;
  localparam logic [18:0] unlock2_byte = 19'h00555;
  localparam logic [18:0] cfi_word = 19'h00055;
  localparam logic [18:0] cfi_byte = 19'h000aa;
  localparam logic [18:0] id_maker = 19'h00000;
  localparam logic [18:0] id_dev_word = 19'h00001;
  localparam logic [18:0] id_dev_byte = 19'h00002;
  localparam logic [18:0] id_prot_word = 19'h00002;
  localparam logic [18:0] id_prot_byte = 19'h00004;
  localparam int sector_lsb = 12;
  // command data bytes
  localparam logic [7:0] d_unlock1 = 8'haa;
  localparam logic [7:0] d_unlock2 = 8'h55;
  localparam logic [7:0] d_reset = 8'hf0;
  localparam logic [7:0] d_autosel = 8'h90;
  localparam logic [7:0] d_secure = 8'h88;
  localparam logic [7:0] d_cfi = 8'h98;
  localparam logic [7:0] d_program = 8'ha0;
  localparam logic [7:0] d_bypass = 8'h20;
  localparam logic [7:0] d_erase_setup = 8'h80;
  localparam logic [7:0] d_chip_erase = 8'h10;
  localparam logic [7:0] d_sector_erase = 8'h30;
  localparam logic [7:0] d_suspend = 8'hb0;
  localparam logic [7:0] d_resume = 8'h30;
  localparam logic [7:0] d_zero = 8'h00;
  // operation codes on the command port
  localparam logic [3:0] op_read = 4'h0;
  localparam logic [3:0] op_reset = 4'h1;
  localparam logic [3:0] op_id_maker = 4'h2;
  localparam logic [3:0] op_id_device = 4'h3;
  localparam logic [3:0] op_prot_verify = 4'h4;
  localparam logic [3:0] op_secure_enter = 4'h5;
  localparam logic [3:0] op_secure_exit = 4'h6;
  localparam logic [3:0] op_cfi = 4'h7;
  localparam logic [3:0] op_program = 4'h8;
  localparam logic [3:0] op_bypass_enter = 4'h9;
  localparam logic [3:0] op_bypass_prog = 4'ha;
  localparam logic [3:0] op_bypass_exit = 4'hb;
  localparam logic [3:0] op_chip_erase = 4'hc;
  localparam logic [3:0] op_sector_erase = 4'hd;
  localparam logic [3:0] op_sector_add = 4'he;
  localparam logic [3:0] op_suspend_resume = 4'hf;
  // bus cycle timing in ns, counts at 50 MHz
  localparam int clk_ns = 20;
  localparam int t_setup_ns = 40;
  localparam int t_pulse_ns = 60;
  localparam int t_hold_ns = 40;
  localparam int t_access_ns = 80;
  localparam int n_setup = (t_setup_ns + clk_ns - 1) / clk_ns;
  localparam int n_pulse = (t_pulse_ns + clk_ns - 1) / clk_ns;
  localparam int n_hold = (t_hold_ns + clk_ns - 1) / clk_ns;
  localparam int n_access = (t_access_ns + clk_ns - 1) / clk_ns;
endpackage : flash_cmd_pkg

// ---- test/flash_cmd_host_checker.sv ----
`timescale 1ns/1ps
// watches strobe order and command strings at the host pins
module flash_cmd_host_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [3:0] req_op,
  input wire logic [18:0] req_addr,
  input wire logic [15:0] req_data,
  input wire logic byte_mode,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic [18:0] a_out,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // a request is taken on an edge where both sides agree
  wire taken = req_valid && req_ready;
  // a write strobe carrying the command byte, soon after the request
  sequence cmd_write(logic [7:0] c);
    ##[1:20] ($fell(we_n) && dq_out[7:0] == c);
  endsequence
  // the write pulse lasts three clocks and then ends
  sequence strobe_pulse;
    !we_n[*3] ##1 we_n;
  endsequence
  strobe_excl_a: assert property (we_n || oe_n)
    else $error("write and output enable low together");
  we_in_ce_a: assert property ($fell(we_n) |-> !$past(ce_n))
    else $error("write strobe fell outside chip select");
  addr_hold_a: assert property (!ce_n && !$past(ce_n)
    |-> $stable(a_out))
    else $error("address moved inside a bus cycle");
  data_hold_a: assert property ($rose(we_n)
    |-> dq_oe && $stable(dq_out))
    else $error("data not held up to the write strobe rise");
  pulse_width_a: assert property ($fell(we_n) |-> strobe_pulse)
    else $error("write pulse of wrong width");
  read_release_a: assert property (!oe_n |-> !dq_oe)
    else $error("host drives data during a read");
  busy_ready_a: assert property (!ce_n |-> !req_ready)
    else $error("ready while a bus cycle runs");
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  reset_cmd_a: assert property (taken &&
    req_op == flash_cmd_pkg::op_reset |-> cmd_write(8'hf0))
    else $error("reset not written");
  prog_open_a: assert property (taken &&
    req_op == flash_cmd_pkg::op_program |-> cmd_write(8'haa))
    else $error("program not unlocked");
  bypass_prog_a: assert property (taken &&
    req_op == flash_cmd_pkg::op_bypass_prog |-> cmd_write(8'ha0))
    else $error("fast program without setup");
  suspend_cmd_a: assert property (taken && !req_data[0] &&
    req_op == flash_cmd_pkg::op_suspend_resume |-> cmd_write(8'hb0))
    else $error("suspend not written");
  resume_cmd_a: assert property (taken && req_data[0] &&
    req_op == flash_cmd_pkg::op_suspend_resume |-> cmd_write(8'h30))
    else $error("resume not written");
  answer_bound_a: assert property (taken |-> ##[1:100] rsp_valid)
    else $error("no answer in time");
endmodule : flash_cmd_host_checker
bind flash_cmd_host flash_cmd_host_checker chk_u (.clk(clk), .rst(rst),
  .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
  .req_addr(req_addr), .req_data(req_data), .byte_mode(byte_mode),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .a_out(a_out),
  .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n),
  .we_n(we_n), .oe_n(oe_n));

// ---- test/flash_dev_model.sv ----
`timescale 1ns/1ps
// behavioural flash answering the host's strobed cycles
module flash_dev_model
#(
  parameter logic [15:0] maker_code = 16'h00a5, // arbitrary value
  parameter logic [15:0] dev_code = 16'h1c3e // arbitrary value
)
(
  input wire logic [18:0] a_out,
  input wire logic [15:0] dq_out,
  output logic [15:0] dq_in,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n
);
  logic [18:0] wa[$];
  logic [15:0] wd[$];
  logic [18:0] la;
  logic id_mode = 1'b0;
  logic live = 1'b0;
  logic [15:0] q = 16'h0000;
  // address taken when the later of the two strobes falls
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n)
    begin
      la = a_out;
      live = 1'b1;
    end
  // data taken at the first rising strobe; only the low byte decodes
  always @(posedge ce_n or posedge we_n)
    if (live)
    begin
      live = 1'b0;
      wa.push_back(la);
      wd.push_back(dq_out);
      if (dq_out[7:0] == 8'h90)
        id_mode = 1'b1;
      else if (dq_out[7:0] == 8'h00 || dq_out[7:0] == 8'hf0)
        id_mode = 1'b0;
    end
  // a released bus inverts its value again on every change of ce_n, oe_n or a_out, so it can show a copy
  always @(ce_n, oe_n, a_out)
    if (!ce_n && !oe_n)
    begin
      if (!id_mode)
        q = ~a_out[15:0];
      else if (a_out[7:0] == 8'h00)
        q = maker_code;
      else if (a_out[7:0] == 8'h01)
        q = dev_code;
      else
        q = {15'h0000, a_out[18:12] == 7'h01};
    end
    else
      q = ~q;
  assign dq_in = q;
endmodule : flash_dev_model

// ---- test/test_flash_cmd_host.sv ----
`timescale 1ns/1ps
// drives operation requests and checks the bus strings and answers
module test_flash_cmd_host;
  typedef struct packed {
    logic [3:0] op;
    logic [18:0] a;
    logic [15:0] d;
    logic bm;
    logic [3:0] n;
    logic [18:0] la;
    logic [7:0] ld;
    logic [15:0] rsp;
  } row_t;
  logic clk;
  logic rst;
  logic req_valid;
  logic req_ready;
  logic [3:0] req_op;
  logic [18:0] req_addr;
  logic [15:0] req_data;
  logic byte_mode;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [18:0] a_out;
  logic [15:0] dq_out;
  logic [15:0] dq_in;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic [15:0] rsp_q;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  // la of 7ffff means the address is free; rows run back to back
  row_t rows [20] = '{
    '{flash_cmd_pkg::op_read, 19'h01234, 16'h0000, 1'b0, 4'h0, 19'h7ffff,
      8'h00, 16'hedcb},
    '{flash_cmd_pkg::op_id_maker, 19'h00000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h90, 16'h00a5},
    '{flash_cmd_pkg::op_id_device, 19'h00000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h90, 16'h1c3e},
    '{flash_cmd_pkg::op_prot_verify, 19'h01000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h90, 16'h0001},
    '{flash_cmd_pkg::op_prot_verify, 19'h02000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h90, 16'h0000}, // unprotected sector
    '{flash_cmd_pkg::op_reset, 19'h00000, 16'h0000, 1'b0, 4'h1, 19'h7ffff,
      8'hf0, 16'h0000},
    '{flash_cmd_pkg::op_cfi, 19'h00000, 16'h0000, 1'b1, 4'h1, 19'h000aa,
      8'h98, 16'h0000}, // issued from array read only
    '{flash_cmd_pkg::op_program, 19'h12345, 16'h12ef, 1'b1, 4'h4,
      19'h12345, 8'hef, 16'h0000},
    '{flash_cmd_pkg::op_bypass_enter, 19'h00000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h20, 16'h0000},
    '{flash_cmd_pkg::op_bypass_prog, 19'h00400, 16'h5a3c, 1'b0, 4'h2,
      19'h00400, 8'h3c, 16'h0000},
    '{flash_cmd_pkg::op_bypass_exit, 19'h00000, 16'h0000, 1'b0, 4'h2,
      19'h7ffff, 8'h00, 16'h0000},
    '{flash_cmd_pkg::op_chip_erase, 19'h00000, 16'h0000, 1'b0, 4'h6,
      19'h00555, 8'h10, 16'h0000},
    '{flash_cmd_pkg::op_sector_erase, 19'h23000, 16'h0000, 1'b0, 4'h6,
      19'h23000, 8'h30, 16'h0000},
    '{flash_cmd_pkg::op_sector_add, 19'h24000, 16'h0000, 1'b0, 4'h1,
      19'h24000, 8'h30, 16'h0000},
    '{flash_cmd_pkg::op_suspend_resume, 19'h00000, 16'h0000, 1'b0, 4'h1,
      19'h7ffff, 8'hb0, 16'h0000}, // only while erase is open
    '{flash_cmd_pkg::op_id_maker, 19'h00000, 16'h0000, 1'b0, 4'h3,
      19'h00555, 8'h90, 16'h00a5}, // id while suspended
    '{flash_cmd_pkg::op_reset, 19'h00000, 16'h0000, 1'b0, 4'h1, 19'h7ffff,
      8'hf0, 16'h0000}, // leave id mode
    '{flash_cmd_pkg::op_suspend_resume, 19'h00000, 16'h0001, 1'b0, 4'h1,
      19'h7ffff, 8'h30, 16'h0000}, // only after a suspend
    '{flash_cmd_pkg::op_secure_enter, 19'h00000, 16'h0000, 1'b1, 4'h3,
      19'h00aaa, 8'h88, 16'h0000},
    '{flash_cmd_pkg::op_secure_exit, 19'h00000, 16'h0000, 1'b0, 4'h4,
      19'h7ffff, 8'h00, 16'h0000}};
  flash_cmd_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .byte_mode(byte_mode), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .a_out(a_out), .dq_out(dq_out), .dq_oe(),
    .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  flash_dev_model dev_u (.a_out(a_out), .dq_out(dq_out), .dq_in(dq_in),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n));
  task check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // one request, then a bounded wait for its answer pulse
  task automatic run(input row_t r);
    int k;
    dev_u.wa.delete();
    dev_u.wd.delete();
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= r.op;
    req_addr <= r.a;
    req_data <= r.d;
    byte_mode <= r.bm;
    @(posedge clk);
    req_valid <= 1'b0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (rsp_valid !== 1'b1 && k < 300);
    check(k < 300, "no answer");
    rsp_q = rsp_data;
  endtask : run
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // a hang ends the run through the same report
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = 4'h0;
    req_addr = 19'h00000;
    req_data = 16'h0000;
    byte_mode = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      run(rows[i]);
      check(dev_u.wd.size() == int'(rows[i].n), "write count");
      if (rows[i].n > 2)
        check(dev_u.wd[0][7:0] === 8'haa && dev_u.wa[0] ===
          (rows[i].bm ? 19'h00aaa : 19'h00555), "first unlock");
      if (rows[i].n > 0)
        check(dev_u.wd[$][7:0] === rows[i].ld, "last command");
      if (rows[i].n > 0 && rows[i].la !== 19'h7ffff)
        check(dev_u.wa[$] === rows[i].la, "last address");
      check(rsp_q === rows[i].rsp, "answer data");
    end
    // reset in the middle of a command string returns to idle
    @(posedge clk);
    req_valid <= 1'b1;
    req_op <= flash_cmd_pkg::op_chip_erase;
    @(posedge clk);
    req_valid <= 1'b0;
    repeat (15) @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(ce_n === 1'b1 && we_n === 1'b1 &&
      req_ready === 1'b1, "reset");
    // full sixteen bit program data straight after a reset
    run('{flash_cmd_pkg::op_program, 19'h3a001, 16'hbeef, 1'b0, 4'h4,
      19'h3a001, 8'hef, 16'h0000});
    check(dev_u.wd[3] === 16'hbeef, "program data");
    check(dev_u.wa[3] === 19'h3a001, "program address");
    summarize();
  end
endmodule : test_flash_cmd_host
